// ==== rtl/agc_pkg.sv ====
// Purpose: Shared constants and types of the gain sequencer block
// Assumes: 40 MHz system clock, byte-wide control registers 1..7
// Notes: Timer scale and maximum gain base are plain defaults
package agc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int REG_N = 8;
  localparam int REG_W = 8;
  localparam int REG_CTRL = 1;
  localparam int REG_ATK = 2;
  localparam int REG_REL = 3;
  localparam int REG_HOLD = 4;
  localparam int REG_FIXG = 5;
  localparam int REG_LIM = 6;
  localparam int REG_MAXG = 7;
  // Entry 0 is unmapped and reads zero
  localparam logic [REG_N*REG_W-1:0] REG_DEFAULTS =
    {8'hc2, 8'h3a, 8'h06, 8'h00, 8'h0b, 8'h05, 8'hc3, 8'h00};
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CTRL_R_EN = 7;
  localparam int CTRL_L_EN = 6;
  localparam int CTRL_SWS = 5;
  localparam int CTRL_NG_EN = 0;
  localparam int TIME_W = 6;
  localparam int FIXG_W = 6;
  localparam int LIM_LSB = 0;
  localparam int LIM_W = 5;
  localparam int NGT_LSB = 5;
  localparam int NGT_W = 2;
  localparam int LIMDIS_BIT = 7;
  localparam int MAXG_LSB = 4;
  localparam int MAXG_W = 4;
  localparam int CR_LSB = 0;
  localparam int CR_W = 2;
  localparam int GAIN_W = 7;
  localparam logic [FIXG_W-1:0] FIXG_DEFAULT = 6'h06;
  localparam logic [FIXG_W-1:0] MAXG_BASE_DB = 6'h12;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 50000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_MS = 5;
  localparam int STARTUP_CYC = (STARTUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] ATK_TICKS_PER_CODE = 16'h0002;
  localparam logic [TMR_W-1:0] REL_TICKS_PER_CODE = 16'h0112;
  localparam logic [TMR_W-1:0] HOLD_TICKS_PER_CODE = 16'h0112;
  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR_DEF = 7'h58;
  localparam logic [3:0] BIT_LAST = 4'h8;
  typedef enum logic [3:0] {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_AACK = 4'b0010,
    I_REG = 4'b0011,
    I_RACK = 4'b0100,
    I_WDAT = 4'b0101,
    I_WACK = 4'b0110,
    I_RDAT = 4'b0111,
    I_MACK = 4'b1000
  } agc_i2c_st_t;
endpackage

// ==== rtl/agc_reg_mem.sv ====
// Purpose: Control register store with registered read port
// Assumes: Entry 0 and entries at or above REG_N are unmapped
// Notes: Unmapped reads return zero, unmapped writes are dropped
module agc_reg_mem import agc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [REG_W-1:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [REG_W-1:0] rdata_o,
  output logic [REG_N*REG_W-1:0] regs_o
);
  logic [REG_W-1:0] mem_q [REG_N];

  // Entry 0 keeps its zero default, writes to it are dropped
  for (genvar i = 0; i < REG_N; i++) begin : g_ent
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mem_q[i] <= REG_DEFAULTS[i*REG_W +: REG_W];
      end else if (we_i && waddr_i == 8'(i) && i != 0) begin
        mem_q[i] <= wdata_i;
      end
    end
  end
  for (genvar j = 0; j < REG_N; j++) begin : g_flat
    assign regs_o[j*REG_W +: REG_W] = mem_q[j];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (raddr_i < 8'(REG_N)) begin
      rdata_o <= mem_q[raddr_i[2:0]];
    end else begin
      rdata_o <= '0;
    end
  end
endmodule // agc_reg_mem

// ==== rtl/agc_seq_top.sv ====
// Purpose: Gain step sequencer with serial register port and start-up control
// Assumes: Level detector inputs are on clk_i; pins are asynchronous
// Notes: Gain is counted in half-dB steps from 0 dB

// Behaviour
// - Gain freezes while input stays below the noise gate threshold.
// - Automatic steps never raise gain above the programmed maximum gain.
// - Decrements need the attack interval elapsed since the last change.
// - Increments need the release interval elapsed since the last change.
// - Any gain change restarts attack, release and hold timing together.
// - First increment after a decrement waits hold if hold exceeds release.
// - Later increments, or all with hold off, use the release interval.
// - Pin high starts active logic; output stage enables 5 ms later.
// - After hardware reset, start at default fixed gain; arm above gate.
// - Leaving soft shutdown starts at the latest fixed gain, no ramp.
// - New fixed gain during playback is reached by timed steps.
// - Both amp enables low holds fixed gain; restart at fixed gain.
// - Clearing both amp enables disables both speaker amplifiers and stops gain steps; core and output stage stay on.
// - Soft shutdown disables amplifier functions, registers kept.
// - Shutdown pin low stops everything and restores register defaults.
// - Bytes move as 8 bits MSB first, each acknowledged.
// - Address byte is 7 bits plus direction; device acks it.
// - Any number of bytes accepted between start and stop.
// - Multi-byte reads return consecutive registers while master acks.
// - Each automatic adjustment moves gain by exactly one half-dB step.
// - Sequential write: first byte sets pointer, data fills next registers.
module agc_seq_top import agc_pkg::*; #(
  parameter int unsigned STARTUP_DELAY_CYC = STARTUP_CYC,
  parameter logic [6:0] DEV_ADDR = I2C_ADDR_DEF
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic shutdown_n_pin_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic above_gate_i,
  input wire logic dec_req_i,
  input wire logic inc_req_i,
  output logic [GAIN_W-1:0] gain_o,
  output logic core_active_o,
  output logic output_stage_en_o,
  output logic right_amp_enable_o,
  output logic left_amp_enable_o,
  output logic [LIM_W-1:0] limiter_level_o,
  output logic limiter_dis_o,
  output logic [NGT_W-1:0] gate_thresh_o,
  output logic [CR_W-1:0] comp_ratio_o
);
  localparam int SC_W = $clog2(STARTUP_DELAY_CYC + 1);
  localparam int TK_W = $clog2(TICK_CYC + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers and reset
  // ----------------------------------------------------------------
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [1:0] sdz_s;
  logic rst;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      sdz_s <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      sdz_s <= {sdz_s[0], shutdown_n_pin_i};
    end
  end

  // Pin low clears logic and registers alike
  assign rst = sys_rst_i | ~sdz_s[1];

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign bus_start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign bus_stop = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  logic wr_q;
  logic [7:0] wr_addr_q;
  logic [REG_W-1:0] wr_dat_q;
  logic [7:0] ptr_q;
  logic [REG_W-1:0] rd_dat;
  logic [REG_N*REG_W-1:0] regs;

  agc_reg_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst),
    .we_i(wr_q),
    .waddr_i(wr_addr_q),
    .wdata_i(wr_dat_q),
    .raddr_i(ptr_q),
    .rdata_o(rd_dat),
    .regs_o(regs)
  );

  logic [REG_W-1:0] r_ctrl;
  logic [REG_W-1:0] r_lim;
  logic [REG_W-1:0] r_maxg;
  logic [TIME_W-1:0] atk_f;
  logic [TIME_W-1:0] rel_f;
  logic [TIME_W-1:0] hold_f;
  logic [FIXG_W-1:0] fix_f;
  assign r_ctrl = regs[REG_CTRL*REG_W +: REG_W];
  assign r_lim = regs[REG_LIM*REG_W +: REG_W];
  assign r_maxg = regs[REG_MAXG*REG_W +: REG_W];
  assign atk_f = regs[REG_ATK*REG_W +: TIME_W];
  assign rel_f = regs[REG_REL*REG_W +: TIME_W];
  assign hold_f = regs[REG_HOLD*REG_W +: TIME_W];
  assign fix_f = regs[REG_FIXG*REG_W +: FIXG_W];

  logic soft_shutdown;
  logic ng_en;
  assign soft_shutdown = r_ctrl[CTRL_SWS];
  assign ng_en = r_ctrl[CTRL_NG_EN];
  assign limiter_level_o = r_lim[LIM_LSB +: LIM_W];
  assign limiter_dis_o = r_lim[LIMDIS_BIT];
  assign gate_thresh_o = r_lim[NGT_LSB +: NGT_W];
  assign comp_ratio_o = r_maxg[CR_LSB +: CR_W];

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  agc_i2c_st_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic drive_q;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      st_q <= I_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      tx_q <= '0;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
      ptr_q <= '0;
      wr_q <= 1'b0;
      wr_addr_q <= '0;
      wr_dat_q <= '0;
    end else begin
      wr_q <= 1'b0;
      if (bus_start) begin
        st_q <= I_ADDR;
        cnt_q <= '0;
        drive_q <= 1'b0;
      end else if (bus_stop) begin
        st_q <= I_IDLE;
        drive_q <= 1'b0;
      end else begin
        case (st_q)
          I_ADDR, I_REG, I_WDAT: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BIT_LAST) begin
              cnt_q <= '0;
              drive_q <= 1'b1;
              if (st_q == I_ADDR) begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  rw_q <= sh_q[0];
                  st_q <= I_AACK;
                end else begin
                  drive_q <= 1'b0;
                  st_q <= I_IDLE;
                end
              end else if (st_q == I_REG) begin
                ptr_q <= sh_q;
                st_q <= I_RACK;
              end else begin
                wr_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_dat_q <= sh_q;
                ptr_q <= ptr_q + 8'h01;
                st_q <= I_WACK;
              end
            end
          end
          I_AACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                tx_q <= rd_dat;
                drive_q <= ~rd_dat[7];
                ptr_q <= ptr_q + 8'h01;
                st_q <= I_RDAT;
              end else begin
                drive_q <= 1'b0;
                st_q <= I_REG;
              end
            end
          end
          I_RACK, I_WACK: begin
            if (scl_fall) begin
              drive_q <= 1'b0;
              st_q <= I_WDAT;
            end
          end
          I_RDAT: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == BIT_LAST) begin
                cnt_q <= '0;
                drive_q <= 1'b0;
                st_q <= I_MACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                drive_q <= ~tx_q[6];
              end
            end
          end
          I_MACK: begin
            if (scl_rise && sda_s[1]) begin
              st_q <= I_IDLE;
            end else if (scl_fall) begin
              tx_q <= rd_dat;
              drive_q <= ~rd_dat[7];
              ptr_q <= ptr_q + 8'h01;
              st_q <= I_RDAT;
            end
          end
          default: begin
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drive_q;

  // ----------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------
  logic [SC_W-1:0] start_cnt_q;
  logic stage_q;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      start_cnt_q <= '0;
      stage_q <= 1'b0;
    end else if (!stage_q) begin
      if (start_cnt_q == SC_W'(STARTUP_DELAY_CYC - 1)) begin
        stage_q <= 1'b1;
      end else begin
        start_cnt_q <= start_cnt_q + 1'b1;
      end
    end
  end

  assign core_active_o = ~rst & ~soft_shutdown;
  assign output_stage_en_o = stage_q & ~soft_shutdown;
  assign right_amp_enable_o = stage_q & ~soft_shutdown & r_ctrl[CTRL_R_EN];
  assign left_amp_enable_o = stage_q & ~soft_shutdown & r_ctrl[CTRL_L_EN];

  // ----------------------------------------------------------------
  // Gain sequencer
  // ----------------------------------------------------------------
  logic [TK_W-1:0] tick_cnt_q;
  logic tick;
  logic tmr_clr;
  // Prescaler restarts with the timer on each gain step so intervals are not cut short
  always_ff @(posedge clk_i) begin
    if (rst || tick || tmr_clr) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = tick_cnt_q == TK_W'(TICK_CYC - 1);

  logic [TMR_W-1:0] atk_lim;
  logic [TMR_W-1:0] rel_lim;
  logic [TMR_W-1:0] hold_lim;
  logic [TMR_W-1:0] inc_lim;
  logic hold_use;
  assign atk_lim = TMR_W'(TMR_W'(atk_f) * ATK_TICKS_PER_CODE);
  assign rel_lim = TMR_W'(TMR_W'(rel_f) * REL_TICKS_PER_CODE);
  assign hold_lim = TMR_W'(TMR_W'(hold_f) * HOLD_TICKS_PER_CODE);
  assign hold_use = (hold_f != '0) && (hold_lim > rel_lim);

  logic [GAIN_W-1:0] gain_q;
  logic [TMR_W-1:0] tmr_q;
  logic last_dn_q;
  logic armed_q;
  logic agc_run;
  logic freeze;
  logic [GAIN_W-1:0] fix_half;
  logic [GAIN_W-1:0] max_half;
  logic dn_need;
  logic up_need;
  logic step_dn;
  logic step_up;

  assign fix_half = {1'b0, fix_f} << 1;
  assign max_half = GAIN_W'({1'b0, MAXG_BASE_DB + FIXG_W'(r_maxg[MAXG_LSB +: MAXG_W])} << 1);
  assign agc_run = stage_q & ~soft_shutdown & (r_ctrl[CTRL_R_EN] | r_ctrl[CTRL_L_EN]);
  assign freeze = ~armed_q | (ng_en & ~above_gate_i);
  assign inc_lim = (last_dn_q && hold_use) ? hold_lim : rel_lim;
  assign dn_need = dec_req_i | (gain_q > max_half) | (~inc_req_i & (gain_q > fix_half));
  assign up_need = ~dec_req_i & (inc_req_i | (gain_q < fix_half));
  assign step_dn = agc_run & ~freeze & dn_need & (tmr_q >= atk_lim) & (gain_q != '0);
  assign step_up = agc_run & ~freeze & up_need & ~step_dn & (tmr_q >= inc_lim)
                   & (gain_q < max_half);
  assign tmr_clr = step_dn | step_up;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      gain_q <= {1'b0, FIXG_DEFAULT} << 1;
      armed_q <= 1'b0;
      tmr_q <= '0;
      last_dn_q <= 1'b0;
    end else if (!agc_run) begin
      gain_q <= fix_half;
      armed_q <= 1'b0;
      tmr_q <= '0;
      last_dn_q <= 1'b0;
    end else begin
      if (above_gate_i) begin
        armed_q <= 1'b1;
      end
      if (step_dn || step_up) begin
        tmr_q <= '0;
        last_dn_q <= step_dn;
        gain_q <= step_dn ? gain_q - 1'b1 : gain_q + 1'b1;
      end else if (tick && tmr_q != '1) begin
        tmr_q <= tmr_q + 1'b1;
      end
    end
  end

  assign gain_o = gain_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  gate_freeze_a: assert property (@(posedge clk_i) disable iff (rst)
    agc_run && $past(agc_run) && ng_en && !$past(above_gate_i) && $past(ng_en) |-> gain_q == $past(gain_q))
    else $error("gain moved below noise gate");
  max_gain_a: assert property (@(posedge clk_i) disable iff (rst)
    agc_run && $past(agc_run) && gain_q > $past(gain_q) |-> gain_q <= max_half)
    else $error("gain raised above maximum");
  attack_gap_a: assert property (@(posedge clk_i) disable iff (rst)
    step_dn |-> tmr_q >= atk_lim && !step_up)
    else $error("decrement before attack interval");
  release_gap_a: assert property (@(posedge clk_i) disable iff (rst)
    step_up && !(last_dn_q && hold_use) |-> tmr_q >= rel_lim)
    else $error("increment before release interval");
  timer_restart_a: assert property (@(posedge clk_i) disable iff (rst)
    (step_up || step_dn) |=> tmr_q == '0 ##1 tmr_q <= 16'h0001)
    else $error("timers not restarted on gain change");
  hold_wait_a: assert property (@(posedge clk_i) disable iff (rst)
    step_up && last_dn_q && hold_use |-> tmr_q >= hold_lim)
    else $error("first increment did not wait hold");
  step_size_a: assert property (@(posedge clk_i) disable iff (rst)
    agc_run && $past(agc_run) && gain_q != $past(gain_q)
      |-> gain_q == $past(gain_q) + 7'h01 || gain_q == $past(gain_q) - 7'h01)
    else $error("gain step not one half dB");
  stage_delay_a: assert property (@(posedge clk_i) disable iff (rst)
    $rose(stage_q) |-> $past(start_cnt_q) == SC_W'(STARTUP_DELAY_CYC - 1))
    else $error("output stage enabled at wrong time");
  fixed_hold_a: assert property (@(posedge clk_i) disable iff (rst)
    !agc_run |=> gain_q == $past(fix_half))
    else $error("gain not at fixed gain while stopped");
  addr_ack_a: assert property (@(posedge clk_i) disable iff (rst)
    st_q == I_AACK && $past(st_q) == I_ADDR |-> !sda_oe_n_o && $past(sh_q[7:1]) == DEV_ADDR)
    else $error("address ack mismatch");
  wr_seq_a: assert property (@(posedge clk_i) disable iff (rst)
    wr_q |-> ptr_q == wr_addr_q + 8'h01)
    else $error("write pointer not advanced");
endmodule // agc_seq_top

// ==== dv/agc_i2c_master_model.sv ====
// Purpose: Serial bus master model for the register port
// Assumes: Open-drain bus with pull-up, 200 ns bus clock period
// Notes: Samples late in the high phase to allow for slave sync delay
module agc_i2c_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus idles released and clock high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    #25;
    sda_o = 1'b1;
    #75;
    scl_o = 1'b1;
    #75;
    sda_o = 1'b0;
    #75;
    scl_o = 1'b0;
  endtask
  task automatic stop();
    #25;
    sda_o = 1'b0;
    #75;
    scl_o = 1'b1;
    #75;
    sda_o = 1'b1;
    #50;
  endtask
  task automatic xbit(input logic b, output logic r);
    #25;
    sda_o = b;
    #75;
    scl_o = 1'b1;
    #90;
    r = sda_i;
    #10;
    scl_o = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, ak);
  endtask
  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(nack, r);
  endtask
endmodule // agc_i2c_master_model

// ==== dv/agc_gain_sequencer_i2c_control_tb.sv ====
// Purpose: Self-checking bench for the gain sequencer top
// Assumes: Short start-up delay parameter, bus master model on the pins
// Notes: Release code 0 is used so increments finish within the run
module agc_gain_sequencer_i2c_control_tb import agc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STUP = 20;
  logic clk_i, sys_rst_i, shutdown_n_pin_i, scl, m_sda, sda_bus;
  logic above_gate_i, dec_req_i, inc_req_i, sda_o, sda_oe_n_o;
  logic core_active_o, output_stage_en_o, right_amp_enable_o, left_amp_enable_o, limiter_dis_o;
  logic [GAIN_W-1:0] gain_o, gmax;
  logic [LIM_W-1:0] limiter_level_o;
  logic [NGT_W-1:0] gate_thresh_o;
  logic [CR_W-1:0] comp_ratio_o;
  int error_cnt, total_checks;
  logic [7:0] dflt[$] = '{8'hc3, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h3a, 8'hc2};
  // Wired-AND bus with pull-up
  assign sda_bus = m_sda & (sda_oe_n_o | sda_o);
  agc_i2c_master_model m (.sda_i(sda_bus), .scl_o(scl), .sda_o(m_sda));
  agc_seq_top #(.STARTUP_DELAY_CYC(STUP)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .shutdown_n_pin_i(shutdown_n_pin_i), .scl_i(scl),
    .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .above_gate_i(above_gate_i),
    .dec_req_i(dec_req_i), .inc_req_i(inc_req_i), .gain_o(gain_o), .core_active_o(core_active_o),
    .output_stage_en_o(output_stage_en_o), .right_amp_enable_o(right_amp_enable_o),
    .left_amp_enable_o(left_amp_enable_o), .limiter_level_o(limiter_level_o),
    .limiter_dis_o(limiter_dis_o), .gate_thresh_o(gate_thresh_o), .comp_ratio_o(comp_ratio_o));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (gain_o > gmax) gmax <= gain_o;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    logic ak;
    m.start();
    m.wbyte({I2C_ADDR_DEF, 1'b0}, ak);
    chk("addr ack", ak, 1'b0);
    m.wbyte(a, ak);
    chk("reg ack", ak, 1'b0);
    foreach (d[i]) begin
      m.wbyte(d[i], ak);
      chk("data ack", ak, 1'b0);
    end
    m.stop();
    cyc(4);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
    logic ak;
    logic [7:0] q;
    m.start();
    m.wbyte({I2C_ADDR_DEF, 1'b0}, ak);
    m.wbyte(a, ak);
    m.start();
    m.wbyte({I2C_ADDR_DEF, 1'b1}, ak);
    chk("read addr ack", ak, 1'b0);
    foreach (e[i]) begin
      m.rbyte(q, i == e.size() - 1);
      chk("read data", q, e[i]);
    end
    m.stop();
    cyc(4);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_startup();
    int n;
    chk("gain at start", gain_o, 7'd12);
    chk("stage early", output_stage_en_o, 1'b0);
    chk("core active", core_active_o, 1'b1);
    for (n = 0; n < 60 && output_stage_en_o !== 1'b1; n++) cyc(1);
    chk("stage delay", n >= 12 && n < 60, 1'b1);
    if (n == 60) stop_test();
    chk("amps on", {right_amp_enable_o, left_amp_enable_o}, 2'b11);
    rd(8'h01, dflt);
  endtask
  task automatic t_bad_addr();
    logic ak;
    m.start();
    m.wbyte({I2C_ADDR_DEF ^ 7'h01, 1'b0}, ak);
    chk("foreign addr", ak, 1'b1);
    m.stop();
    cyc(4);
  endtask
  task automatic t_seq();
    wr(8'h02, '{8'h01, 8'h00, 8'h00, 8'h06, 8'h5f, 8'h01});
    rd(8'h02, '{8'h01, 8'h00, 8'h00, 8'h06, 8'h5f, 8'h01});
    chk("limiter", {limiter_dis_o, gate_thresh_o, limiter_level_o}, 8'h5f);
    chk("ratio", comp_ratio_o, 2'b01);
  endtask
  task automatic t_gain();
    int t0, t1, n;
    logic [GAIN_W-1:0] g;
    inc_req_i = 1'b1;
    cyc(2000);
    chk("gate freeze", gain_o, 7'd12);
    above_gate_i = 1'b1;
    gmax = '0;
    cyc(300);
    chk("max gain", gain_o, 7'd36);
    chk("never above max", gmax, 7'd36);
    inc_req_i = 1'b0;
    dec_req_i = 1'b1;
    t0 = 0;
    t1 = 0;
    g = gain_o;
    for (n = 1; n < 20000 && t1 == 0; n++) begin
      cyc(1);
      if (gain_o !== g) begin
        chk("one step", gain_o, g - 7'd1);
        g = gain_o;
        if (t0 == 0) t0 = n;
        else t1 = n;
      end
    end
    chk("restart on step", t0 >= 2 * TICK_CYC - 300, 1'b1);
    chk("attack gap", t1 - t0 >= 2 * TICK_CYC && t1 - t0 <= 3 * TICK_CYC + 4, 1'b1);
    if (t1 == 0) stop_test();
    dec_req_i = 1'b0;
    above_gate_i = 1'b0;
    g = gain_o;
    cyc(9000);
    chk("below gate", gain_o, g);
  endtask
  task automatic t_amp();
    wr(8'h01, '{8'h01});
    chk("amps off", {right_amp_enable_o, left_amp_enable_o}, 2'b00);
    chk("others run", {output_stage_en_o, core_active_o}, 2'b11);
    chk("fixed while off", gain_o, 7'd12);
    wr(8'h01, '{8'hc1});
    chk("amps back", {right_amp_enable_o, left_amp_enable_o}, 2'b11);
    chk("restart fixed", gain_o, 7'd12);
  endtask
  task automatic t_soft();
    wr(8'h01, '{8'he1});
    chk("soft core", core_active_o, 1'b0);
    chk("soft amps", {right_amp_enable_o, left_amp_enable_o}, 2'b00);
    wr(8'h05, '{8'h0c});
    rd(8'h01, '{8'he1, 8'h01, 8'h00, 8'h00, 8'h0c});
    wr(8'h01, '{8'hc1});
    chk("new fixed gain", gain_o, 7'd24);
    chk("core back", core_active_o, 1'b1);
    above_gate_i = 1'b1;
    wr(8'h05, '{8'h0d});
    chk("playback fixed", gain_o, 7'd26);
    above_gate_i = 1'b0;
  endtask
  task automatic t_pin();
    // Pin held until the shutdown has fully taken effect
    shutdown_n_pin_i = 1'b0;
    cyc(6);
    chk("pin off", {core_active_o, output_stage_en_o, sda_oe_n_o}, 3'b001);
    chk("pin gain", gain_o, 7'd12);
    shutdown_n_pin_i = 1'b1;
    cyc(5);
    chk("pin limiter", {limiter_dis_o, gate_thresh_o, limiter_level_o}, 8'h3a);
    rd(8'h01, dflt);
  endtask
  initial begin
    sys_rst_i = 1'b1;
    shutdown_n_pin_i = 1'b1;
    above_gate_i = 1'b0;
    dec_req_i = 1'b0;
    inc_req_i = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    gmax = '0;
    cyc(16);
    sys_rst_i = 1'b0;
    cyc(5);
    t_startup();
    t_bad_addr();
    t_seq();
    t_gain();
    t_amp();
    t_soft();
    t_pin();
    stop_test();
  end
endmodule // agc_gain_sequencer_i2c_control_tb
